// *** common/cbh_consts.vh ***
// Purpose: constants shared by the block-transfer command interpreter
// Assumes: 16-bit block words, 64-word request and reply blocks
// Notes:   definitions only
`ifndef CBH_CONSTS_VH
`define CBH_CONSTS_VH

`define CBH_WORD_W 16
`define CBH_REC_W 96
`define CBH_QUEUE_W 97
`define CBH_BLK_AW 6

// block codes 9901, 9902 and 9903
`define CBH_CODE_USER 16'h26ad
`define CBH_CODE_LIST 16'h26ae
`define CBH_CODE_EVENT 16'h26af

// word offsets inside a block
`define CBH_W_SEQ 6'h00
`define CBH_W_CODE 6'h01
`define CBH_W_CNT 6'h02
`define CBH_W_FIRST 6'h03
`define CBH_W_LAST 6'h3f

// count limits and record shape
`define CBH_CNT_MIN 16'h0001
`define CBH_USER_MAX 16'h000a
`define CBH_LIST_MAX 16'h003c
`define CBH_REC_LAST 3'h5
`define CBH_EVT_MAX 8'h04
`define CBH_EVT_WORDS 7'h0e
`define CBH_EVT_FIRST 7'h03

// queue entry kind flag
`define CBH_KIND_USER 1'b0
`define CBH_KIND_LIST 1'b1

`endif

// *** hw/cbh_mem.v ***
// Purpose: simple dual-port memory with registered read data
// Assumes: one write port and one read port on the same clock
// Notes:   contents are not reset, only the read register is
`timescale 1ns/1ps
`default_nettype none

module cbh_mem #(
   parameter W = 16,
   parameter D = 64,
   parameter AW = 6
) (
   // clock and reset
   input wire ref_clk_i,
   input wire reset_n_i,
   // write port
   input wire we_i,
   input wire [AW-1:0] waddr_i,
   input wire [W-1:0] wdata_i,
   // read port
   input wire re_i,
   input wire [AW-1:0] raddr_i,
   output wire [W-1:0] rdata_o
);

   reg [W-1:0] mem [0:D-1];
   reg [W-1:0] rdata_r;

   always @(posedge ref_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rdata_r <= {W{1'b0}};
      end else if (re_i) begin
         rdata_r <= mem[raddr_i];
      end
   end

   assign rdata_o = rdata_r;

endmodule // cbh_mem

`default_nettype wire

// *** hw/cbh_block_handler.v ***
// Purpose: interprets request blocks and builds reply blocks
// Assumes: processor writes processor_to_module_area, then pulses go
// Notes:   reply goes out word by word into module_to_processor_area
// Operation
// - code 9901 appends every contained command to the pending queue.
// - word 2 of 9901 holds command count, valid 1 to 10.
// - 9901 records are six words each, words 3 to 62, 63 unused.
// - order: database address, session, sector, type, object, qualifier.
// - 9901 reply: fresh sequence in word 0, 9901 in word 1, rest unused.
// - 9902 queues listed entries regardless of their enable flag.
// - 9902 word 2 count 1 to 60, entries in words 3 to 62.
// - 9902 entries are zero-based indices, queued for immediate processing.
// - 9902 reply: fresh sequence in word 0, 9902 in word 1.
// - word 1 block code selects which handler runs.
// - queue holds up to 100 commands; active count is reported.
// - 9903 reply word 2 holds event count 1 to 4, fourteen words each; 0 is sent when evt_avail_i is 0.
`timescale 1ns/1ps
`default_nettype none
`include "cbh_consts.vh"

module cbh_block_handler #(
   parameter QDEPTH = 100,
   parameter QAW = 7
) (
   // clock and reset
   input wire ref_clk_i,
   input wire reset_n_i,
   // processor_to_module_area writes
   input wire req_we_i,
   input wire [5:0] req_addr_i,
   input wire [15:0] req_data_i,
   input wire req_go_i,
   // module_to_processor_area writes
   output wire rsp_we_o,
   output wire [5:0] rsp_addr_o,
   output wire [15:0] rsp_data_o,
   output wire rsp_done_o,
   // command queue drain
   input wire cmd_req_i,
   output wire cmd_ack_o,
   output wire cmd_kind_o,
   output wire [95:0] cmd_data_o,
   output wire [QAW-1:0] queue_count_o,
   // buffered events
   input wire [7:0] evt_avail_i,
   input wire evt_valid_i,
   input wire [15:0] evt_word_i,
   output wire evt_ready_o,
   // status
   output wire busy_o,
   output wire drop_o
);

   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_H0 = 7'h02;
   localparam [6:0] S_H1 = 7'h04;
   localparam [6:0] S_H2 = 7'h08;
   localparam [6:0] S_CMD = 7'h10;
   localparam [6:0] S_LIST = 7'h20;
   localparam [6:0] S_REPLY = 7'h40;

   function in_rng;
      input [15:0] v;
      input [15:0] hi;
      begin
         in_rng = (v >= `CBH_CNT_MIN) && (v <= hi);
      end
   endfunction

   reg [6:0] st_r;
   reg [5:0] rd_r;
   reg [5:0] rd_nxt;
   reg [15:0] seq_r;
   reg [15:0] code_r;
   reg [5:0] cnt_r;
   reg [15:0] last_seq_r;
   reg have_last_r;
   reg [15:0] out_seq_r;
   reg [2:0] k_r;
   reg [5:0] n_r;
   reg [79:0] sh_r;
   reg [2:0] ecnt_r;
   reg [5:0] rp_r;
   reg rsp_we_r;
   reg [5:0] rsp_addr_r;
   reg [15:0] rsp_data_r;
   reg rsp_done_r;
   reg drop_r;
   reg [QAW-1:0] wp_r;
   reg [QAW-1:0] rp_q_r;
   reg [QAW-1:0] qcnt_r;
   reg ack_r;
   reg [15:0] word;
   reg adv;
   reg in_evt;

   wire [15:0] rdata;
   wire [`CBH_QUEUE_W-1:0] qrdata;
   wire [`CBH_QUEUE_W-1:0] qwdata;
   wire push;
   wire pop;
   wire [7:0] room;
   wire [6:0] ev_end;
   wire [7:0] ev_lim;
   wire q_wait;
   wire user_ok;
   wire list_ok;
   wire dup;

   cbh_mem #(.W(`CBH_WORD_W), .D(64), .AW(`CBH_BLK_AW)) u_req_area (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .we_i(req_we_i),
      .waddr_i(req_addr_i),
      .wdata_i(req_data_i),
      .re_i(1'b1),
      .raddr_i(rd_nxt),
      .rdata_o(rdata)
   );

   cbh_mem #(.W(`CBH_QUEUE_W), .D(QDEPTH), .AW(QAW)) u_queue (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .we_i(push),
      .waddr_i(wp_r),
      .wdata_i(qwdata),
      .re_i(pop),
      .raddr_i(rp_q_r),
      .rdata_o(qrdata)
   );

   assign room = QDEPTH[7:0] - {{(8-QAW){1'b0}}, qcnt_r};
   // repeat sequence value is not acted on
   assign dup = have_last_r && (seq_r == last_seq_r);
   assign user_ok = in_rng(rdata, `CBH_USER_MAX);
   assign list_ok = in_rng(rdata, `CBH_LIST_MAX);
   // accepted block stalls in H2 until the queue has room
   assign q_wait = !dup && (room < {2'h0, rdata[5:0]}) &&
                   (((code_r == `CBH_CODE_USER) && user_ok) ||
                    ((code_r == `CBH_CODE_LIST) && list_ok));

   // one push per finished six-word record
   // each entry number becomes one queue entry
   assign push = ((st_r == S_CMD) && (k_r == `CBH_REC_LAST)) ||
                 (st_r == S_LIST);
   // record kept in arrival order, first word highest
   // enable flag never consulted for listed entries
   assign qwdata = (st_r == S_LIST) ?
                   {`CBH_KIND_LIST, 80'h0, rdata} :
                   {`CBH_KIND_USER, sh_r, rdata};
   assign pop = cmd_req_i && (qcnt_r != {QAW{1'b0}});

   // event words run from word 3 for fourteen per event
   assign ev_end = `CBH_EVT_FIRST + `CBH_EVT_WORDS * {4'h0, ecnt_r};
   assign ev_lim = (evt_avail_i > `CBH_EVT_MAX) ? `CBH_EVT_MAX : evt_avail_i;

   always @* begin
      rd_nxt = rd_r;
      if (st_r == S_IDLE) begin
         rd_nxt = `CBH_W_SEQ;
      end else if (st_r == S_H0) begin
         rd_nxt = `CBH_W_CODE;
      end else if (st_r == S_H1) begin
         rd_nxt = `CBH_W_CNT;
      end else if (st_r == S_H2) begin
         // keep word 2 on the read port while waiting for room
         rd_nxt = q_wait ? `CBH_W_CNT : `CBH_W_FIRST;
      end else if ((st_r == S_CMD) || (st_r == S_LIST)) begin
         rd_nxt = rd_r + 6'h01;
      end
   end

   always @* begin
      word = 16'h0000;
      adv = 1'b1;
      in_evt = 1'b0;
      if (rp_r == `CBH_W_SEQ) begin
         word = out_seq_r;
      end else if (rp_r == `CBH_W_CODE) begin
         word = code_r;
      end else if (rp_r == `CBH_W_CNT) begin
         if (code_r == `CBH_CODE_EVENT) begin
            word = {13'h0000, ecnt_r};
         end
      end else if ((code_r == `CBH_CODE_EVENT) && ({1'b0, rp_r} < ev_end)) begin
         in_evt = 1'b1;
         word = evt_word_i;
         adv = evt_valid_i;
      end
   end

   assign evt_ready_o = (st_r == S_REPLY) && in_evt;

   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         st_r <= S_IDLE;
         rd_r <= `CBH_W_SEQ;
         seq_r <= 16'h0000;
         code_r <= 16'h0000;
         cnt_r <= 6'h00;
         last_seq_r <= 16'h0000;
         have_last_r <= 1'b0;
         out_seq_r <= 16'h0000;
         k_r <= 3'h0;
         n_r <= 6'h00;
         sh_r <= 80'h0;
         ecnt_r <= 3'h0;
         rp_r <= `CBH_W_SEQ;
         rsp_we_r <= 1'b0;
         rsp_addr_r <= 6'h00;
         rsp_data_r <= 16'h0000;
         rsp_done_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         rd_r <= rd_nxt;
         rsp_we_r <= 1'b0;
         rsp_done_r <= 1'b0;
         drop_r <= 1'b0;
         case (st_r)
            S_IDLE: begin
               if (req_go_i) begin
                  st_r <= S_H0;
               end
            end
            S_H0: begin
               seq_r <= rdata;
               st_r <= S_H1;
            end
            S_H1: begin
               code_r <= rdata;
               st_r <= S_H2;
            end
            S_H2: begin
               cnt_r <= rdata[5:0];
               k_r <= 3'h0;
               n_r <= 6'h00;
               rp_r <= `CBH_W_SEQ;
               ecnt_r <= ev_lim[2:0];
               if (dup) begin
                  st_r <= S_IDLE;
                  drop_r <= 1'b1;
               end else if ((code_r == `CBH_CODE_USER) && user_ok) begin
                  // waits here, word 2 held, until the queue has room
                  if (room >= {2'h0, rdata[5:0]}) begin
                     st_r <= S_CMD;
                     last_seq_r <= seq_r;
                     have_last_r <= 1'b1;
                  end
               end else if ((code_r == `CBH_CODE_LIST) && list_ok) begin
                  if (room >= {2'h0, rdata[5:0]}) begin
                     st_r <= S_LIST;
                     last_seq_r <= seq_r;
                     have_last_r <= 1'b1;
                  end
               end else if (code_r == `CBH_CODE_EVENT) begin
                  st_r <= S_REPLY;
                  last_seq_r <= seq_r;
                  have_last_r <= 1'b1;
                  out_seq_r <= out_seq_r + 16'h0001;
               end else begin
                  // bad count or unknown code dropped
                  st_r <= S_IDLE;
                  drop_r <= 1'b1;
               end
            end
            // six words per record from word 3 on
            S_CMD: begin
               if (k_r == `CBH_REC_LAST) begin
                  k_r <= 3'h0;
                  n_r <= n_r + 6'h01;
                  if (n_r + 6'h01 == cnt_r) begin
                     st_r <= S_REPLY;
                     out_seq_r <= out_seq_r + 16'h0001;
                  end
               end else begin
                  sh_r <= {sh_r[63:0], rdata};
                  k_r <= k_r + 3'h1;
               end
            end
            S_LIST: begin
               n_r <= n_r + 6'h01;
               if (n_r + 6'h01 == cnt_r) begin
                  st_r <= S_REPLY;
                  out_seq_r <= out_seq_r + 16'h0001;
               end
            end
            // reply with fresh sequence and code, spare words zero
            // same reply shape for list blocks
            S_REPLY: begin
               if (adv) begin
                  rsp_we_r <= 1'b1;
                  rsp_addr_r <= rp_r;
                  rsp_data_r <= word;
                  rp_r <= rp_r + 6'h01;
                  if (rp_r == `CBH_W_LAST) begin
                     rsp_done_r <= 1'b1;
                     st_r <= S_IDLE;
                  end
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         wp_r <= {QAW{1'b0}};
         rp_q_r <= {QAW{1'b0}};
         qcnt_r <= {QAW{1'b0}};
         ack_r <= 1'b0;
      end else begin
         ack_r <= pop;
         if (push) begin
            wp_r <= (wp_r == QDEPTH[QAW-1:0] - 1'b1) ?
                    {QAW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_q_r <= (rp_q_r == QDEPTH[QAW-1:0] - 1'b1) ?
                      {QAW{1'b0}} : rp_q_r + 1'b1;
         end
         if (push && !pop) begin
            qcnt_r <= qcnt_r + 1'b1;
         end else if (pop && !push) begin
            qcnt_r <= qcnt_r - 1'b1;
         end
      end
   end

   assign rsp_we_o = rsp_we_r;
   assign rsp_addr_o = rsp_addr_r;
   assign rsp_data_o = rsp_data_r;
   assign rsp_done_o = rsp_done_r;
   assign cmd_ack_o = ack_r;
   assign cmd_kind_o = qrdata[96];
   assign cmd_data_o = qrdata[95:0];
   assign queue_count_o = qcnt_r;
   assign busy_o = (st_r != S_IDLE);
   assign drop_o = drop_r;

endmodule // cbh_block_handler

`default_nettype wire

// *** verification/cbh_block_handler_asserts.sv ***
// Purpose: port checker for the block handler
// Assumes: one clock, synchronous active-low reset
// Notes:   tracks the last reply code and sequence word
`timescale 1ns/1ps
`default_nettype none
`include "cbh_consts.vh"
module cbh_chk #(
   parameter QDEPTH = 100,
   parameter QAW = 7
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // handshake
   input wire logic req_go_i,
   input wire logic busy_o,
   input wire logic drop_o,
   // reply
   input wire logic rsp_we_o,
   input wire logic [5:0] rsp_addr_o,
   input wire logic [15:0] rsp_data_o,
   input wire logic rsp_done_o,
   // queue
   input wire logic cmd_req_i,
   input wire logic cmd_ack_o,
   input wire logic [QAW-1:0] queue_count_o
);
   logic [15:0] code_r;
   logic [15:0] seq_r;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         code_r <= 16'h0;
         seq_r <= 16'h0;
      end else if (rsp_we_o && rsp_addr_o == `CBH_W_CODE) begin
         code_r <= rsp_data_o;
      end else if (rsp_we_o && rsp_addr_o == `CBH_W_SEQ) begin
         seq_r <= rsp_data_o;
      end
   end
   go_busy_a:
      assert property (req_go_i && !busy_o |=> busy_o)
      else $error("go not taken");
   code_word_a:
      assert property (rsp_we_o && rsp_addr_o == `CBH_W_CODE |-> rsp_data_o
         inside {`CBH_CODE_USER, `CBH_CODE_LIST, `CBH_CODE_EVENT})
      else $error("bad reply code");
   spare_zero_a:
      assert property (rsp_we_o && rsp_addr_o >= `CBH_W_CNT &&
         code_r != `CBH_CODE_EVENT |-> rsp_data_o == 16'h0)
      else $error("spare word not zero");
   seq_fresh_a:
      assert property (rsp_we_o && rsp_addr_o == `CBH_W_SEQ |->
         rsp_data_o != seq_r)
      else $error("stale sequence");
   done_after_a:
      assert property (rsp_we_o && rsp_addr_o == `CBH_W_LAST |-> rsp_done_o)
      else $error("done missing");
   pop_ack_a:
      assert property (cmd_req_i && queue_count_o != 0 |=> cmd_ack_o)
      else $error("pop not acked");
   queue_max_a:
      assert property (queue_count_o <= QDEPTH)
      else $error("queue over depth");
   drop_quiet_a:
      assert property (drop_o |-> !rsp_we_o [*4])
      else $error("reply after drop");
   evt_count_a:
      assert property (rsp_we_o && rsp_addr_o == `CBH_W_CNT &&
         code_r == `CBH_CODE_EVENT |-> rsp_data_o <= 16'h4)
      else $error("event count high");
   cover property (drop_o);
   cover property (rsp_done_o);
   cover property (cmd_ack_o && queue_count_o == 0);
endmodule // cbh_chk
bind cbh_block_handler cbh_chk #(.QDEPTH(QDEPTH), .QAW(QAW)) chk_u (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_go_i(req_go_i),
   .busy_o(busy_o), .drop_o(drop_o), .rsp_we_o(rsp_we_o),
   .rsp_addr_o(rsp_addr_o), .rsp_data_o(rsp_data_o),
   .rsp_done_o(rsp_done_o), .cmd_req_i(cmd_req_i), .cmd_ack_o(cmd_ack_o),
   .queue_count_o(queue_count_o)
);
`default_nettype wire

// *** verification/cbh_proc_model.sv ***
// Purpose: processor side: collects replies, feeds event words
// Assumes: reply words arrive one per cycle
// Notes:   event source rests one cycle after each word taken
`timescale 1ns/1ps
`default_nettype none
module cbh_proc_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // reply writes
   input wire logic rsp_we_i,
   input wire logic [5:0] rsp_addr_i,
   input wire logic [15:0] rsp_data_i,
   // event stream
   input wire logic evt_ready_i,
   output logic evt_valid_o,
   output logic [15:0] evt_word_o
);
   logic [15:0] reply_r [64];
   logic [15:0] cnt_r;
   logic took_r;
   // valid holds until a word is taken, then drops for one cycle
   always @(negedge ref_clk_i) evt_valid_o <= reset_n_i & ~took_r;
   // idle word inverted so a stale capture shows up
   assign evt_word_o = evt_valid_o ? 16'h0100 + cnt_r : ~(16'h0100 + cnt_r);
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cnt_r <= 16'h0;
         took_r <= 1'b0;
      end else begin
         took_r <= evt_valid_o && evt_ready_i;
         if (evt_valid_o && evt_ready_i) cnt_r <= cnt_r + 16'h1;
      end
      if (rsp_we_i) reply_r[rsp_addr_i] <= rsp_data_i;
   end
endmodule // cbh_proc_model
`default_nettype wire

// *** verification/cbh_block_handler_test.sv ***
// Purpose: self-checking bench for the block handler
// Assumes: inputs change on the falling edge
// Notes:   replies are read from the partner model
`timescale 1ns/1ps
`default_nettype none
`include "cbh_consts.vh"
module cbh_block_handler_test;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, req_we_i = 1'b0;
   logic req_go_i = 1'b0, cmd_req_i = 1'b0;
   logic [5:0] req_addr_i = 6'h0;
   logic [15:0] req_data_i = 16'h0;
   logic [7:0] evt_avail_i = 8'h0;
   logic rsp_we_o, rsp_done_o, cmd_ack_o, cmd_kind_o, evt_ready_o;
   logic busy_o, drop_o, evt_valid_i;
   logic [5:0] rsp_addr_o;
   logic [15:0] rsp_data_o, evt_word_i;
   logic [95:0] cmd_data_o;
   logic [6:0] queue_count_o;
   logic [97:0] exq[$];
   int bad_count = 0, n_checks = 0;
   logic [15:0] seq = 16'h0, rseq = 16'h0, evn = 16'h0;
   cbh_block_handler dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .req_we_i(req_we_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i),
      .req_go_i(req_go_i), .rsp_we_o(rsp_we_o), .rsp_addr_o(rsp_addr_o),
      .rsp_data_o(rsp_data_o), .rsp_done_o(rsp_done_o),
      .cmd_req_i(cmd_req_i), .cmd_ack_o(cmd_ack_o), .cmd_kind_o(cmd_kind_o),
      .cmd_data_o(cmd_data_o), .queue_count_o(queue_count_o),
      .evt_avail_i(evt_avail_i), .evt_valid_i(evt_valid_i),
      .evt_word_i(evt_word_i), .evt_ready_o(evt_ready_o), .busy_o(busy_o),
      .drop_o(drop_o));
   cbh_proc_model p_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .rsp_we_i(rsp_we_o), .rsp_addr_i(rsp_addr_o), .rsp_data_i(rsp_data_o),
      .evt_ready_i(evt_ready_o), .evt_valid_o(evt_valid_i),
      .evt_word_o(evt_word_i));
   initial forever #12.5 ref_clk_i = ~ref_clk_i;
   task automatic chk(input logic [97:0] got, input logic [97:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input int a, input logic [15:0] d);
      req_we_i = 1'b1;
      req_addr_i = 6'(a);
      req_data_i = d;
      @(negedge ref_clk_i);
   endtask
   function automatic logic [95:0] rw(input int b);
      for (int k = 0; k < 6; k++) rw[95-16*k -: 16] = 16'(b + k) ^ 16'h5a00;
   endfunction
   // header words, fire, wait for reply or drop
   task automatic run(input logic [15:0] c, n, input logic dr);
      int i;
      logic ds, rs;
      wr(0, seq);
      wr(1, c);
      wr(2, n);
      req_we_i = 1'b0;
      req_go_i = 1'b1;
      @(negedge ref_clk_i);
      req_go_i = 1'b0;
      ds = 1'b0;
      rs = 1'b0;
      for (i = 0; i < 5000; i++) begin
         ds |= (drop_o === 1'b1);
         rs |= (rsp_done_o === 1'b1);
         if (i > 4 && busy_o === 1'b0 && (ds || rs)) break;
         @(negedge ref_clk_i);
      end
      if (i == 5000) begin
         bad_count++;
         stop_test;
      end
      // done comes with the last word; let the model store it
      @(negedge ref_clk_i);
      chk(98'({ds, rs}), 98'({dr, !dr}));
      if (!dr) rseq++;
   endtask
   task automatic chk_reply(input logic [15:0] c, input int ev);
      logic [15:0] e;
      for (int i = 0; i < 64; i++) begin
         e = (i == 0) ? rseq : (i == 1) ? c : 16'h0;
         if (i == 2) e = 16'(ev);
         if (i >= 3 && i < 3 + 14 * ev) e = 16'h0100 + evn + 16'(i - 3);
         chk(98'(p_u.reply_r[i]), 98'(e));
      end
      evn += 16'(14 * ev);
   endtask
   task pop_all;
      cmd_req_i = 1'b1;
      while (exq.size() > 0) begin
         @(negedge ref_clk_i);
         chk({cmd_ack_o, cmd_kind_o, cmd_data_o}, exq.pop_front());
      end
      cmd_req_i = 1'b0;
   endtask
   task t_user;
      for (int i = 3; i < 64; i++) wr(i, 16'(i) ^ 16'h5a00);
      for (int r = 0; r < 10; r++) exq.push_back({2'b10, rw(3 + 6 * r)});
      seq++;
      run(`CBH_CODE_USER, 16'd10, 1'b0);
      chk_reply(`CBH_CODE_USER, 0);
      chk(98'(queue_count_o), 98'd10);
      pop_all;
   endtask
   task t_list;
      for (int j = 0; j < 60; j++) wr(3 + j, 16'(59 - j));
      for (int p = 0; p < 2; p++)
         for (int j = 0; j < 60; j++) exq.push_back({2'b11, 96'(59 - j)});
      seq++;
      run(`CBH_CODE_LIST, 16'd60, 1'b0);
      chk_reply(`CBH_CODE_LIST, 0);
      chk(98'(queue_count_o), 98'd60);
      seq++;
      // second block must wait for room, then queue all 60
      fork
         run(`CBH_CODE_LIST, 16'd60, 1'b0);
         begin
            repeat (20) @(negedge ref_clk_i);
            chk(98'(busy_o), 98'd1);
            chk(98'(queue_count_o), 98'd60);
            pop_all;
         end
      join
      chk_reply(`CBH_CODE_LIST, 0);
      chk(98'(queue_count_o), 98'd0);
   endtask
   task t_drop;
      seq++;
      run(`CBH_CODE_USER, 16'd0, 1'b1);
      seq++;
      run(`CBH_CODE_USER, 16'd11, 1'b1);
      seq++;
      run(`CBH_CODE_LIST, 16'd61, 1'b1);
      seq++;
      run(16'h26b0, 16'd1, 1'b1);
      seq++;
      run(`CBH_CODE_LIST, 16'd1, 1'b0);
      run(`CBH_CODE_LIST, 16'd1, 1'b1);
      chk(98'(queue_count_o), 98'd1);
      exq.push_back({2'b11, 96'd59});
      pop_all;
   endtask
   task automatic t_event(input logic [7:0] av);
      evt_avail_i = av;
      seq++;
      run(`CBH_CODE_EVENT, 16'h0, 1'b0);
      chk_reply(`CBH_CODE_EVENT, (av > 4) ? 4 : int'(av));
   endtask
   initial begin
      repeat (8) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      @(negedge ref_clk_i);
      t_user;
      t_list;
      t_drop;
      t_event(8'd2);
      t_event(8'd6);
      stop_test;
   end
endmodule // cbh_block_handler_test
`default_nettype wire
